/* File: hdl/opt_pkg.sv */
// constants and field layout for the timer prescaler option block
// How it works
// - option register is software readable and writable
// - one prescaler serves timer or watchdog only
// - watchdog assignment leaves timer clocked undivided
// - rate gives timer 2^(n+1), watchdog 2^n
// - per-pin pull-up mask beside global disable
// - peripheral interrupts need the global gate bit
package opt_pkg;
   localparam logic [7:0] option_addr = 8'h81;
   localparam logic [7:0] option_alt_addr = 8'h8f;
   localparam logic [7:0] pullup_mask_addr = 8'h95;
   localparam logic [7:0] int_ctrl_addr = 8'h8b;
   localparam logic [7:0] timer_addr = 8'h01;
   localparam logic [7:0] ev_status_addr = 8'h90;
   localparam logic [7:0] ev_clear_addr = 8'h91;
   localparam logic [7:0] ev_enable_addr = 8'h92;
   localparam logic [7:0] option_reset = 8'hff;
   localparam logic [7:0] pullup_mask_reset = 8'hff;
   localparam logic [7:0] int_ctrl_reset = 8'h00;
   localparam logic [1:0] ev_reset = 2'h0;
   localparam int pullup_dis_bit = 7;
   localparam int ext_edge_bit = 6;
   localparam int clk_src_bit = 5;
   localparam int src_edge_bit = 4;
   localparam int assign_bit = 3;
   localparam int periph_gate_bit = 6;
   localparam int glob_int_bit = 7;
   localparam int ev_timer_ovf = 0;
   localparam int ev_ext_int = 1;
   localparam logic [7:0] rate_width_all = 8'hff;
endpackage : opt_pkg

/* File: hdl/prescaler_core.sv */
// shared prescaler counter with rate tap select
`timescale 1ns/1ps
module prescaler_core
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic [2:0] rate,
   input wire logic clear,
   output logic tap_timer,
   output logic tap_wdog
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [8:0] mask_t;
   logic [8:0] ext_cnt;

   // wrap-around count, clear resets the chain
   assign cnt_d = clear ? 8'h00 : (tick ? cnt_q + 8'h01 : cnt_q);
   assign ext_cnt = {1'b0, cnt_q};
   assign mask_t = (9'h002 << rate) - 9'h001;
   assign tap_timer = tick & ((ext_cnt & mask_t) == mask_t);
   assign tap_wdog = tick & ((ext_cnt & (mask_t >> 1)) == (mask_t >> 1));

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= 8'h00;
      else
         cnt_q <= cnt_d;
   end
endmodule : prescaler_core

/* File: hdl/timer_prescaler_option_reg.sv */
// option register, shared prescaler, timer and interrupt gating
`timescale 1ns/1ps
module timer_prescaler_option_reg
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   input wire logic timer_pin,
   input wire logic ext_int_pin,
   input wire logic wdog_tick,
   input wire logic [7:0] periph_int_req,
   output logic wdog_timeout,
   output logic [7:0] port_b_pullup_en,
   output logic core_int,
   output logic irq
);
   logic rst_s1_q;
   logic rst_n;
   logic [7:0] timer_prescaler_option_q;
   logic [7:0] port_b_pullup_mask_q;
   logic [7:0] interrupt_control_q;
   logic [7:0] eight_bit_timer_q;
   logic [1:0] ev_status_q;
   logic [1:0] ev_enable_q;
   logic [2:0] tpin_q;
   logic [2:0] epin_q;
   logic [7:0] rdata_q;
   logic [7:0] pullup_q;
   logic core_int_q;
   logic irq_q;
   logic wdog_q;

   // reset release through two flops
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   // pin synchronisers, third stage for edge detect
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tpin_q <= 3'h0;
         epin_q <= 3'h0;
      end
      else
      begin
         tpin_q <= {tpin_q[1:0], timer_pin};
         epin_q <= {epin_q[1:0], ext_int_pin};
      end
   end

   // field decode
   wire pullup_global_disable = timer_prescaler_option_q[opt_pkg::pullup_dis_bit];
   wire ext_int_edge_sel = timer_prescaler_option_q[opt_pkg::ext_edge_bit];
   wire timer_clk_src_sel = timer_prescaler_option_q[opt_pkg::clk_src_bit];
   wire timer_src_edge_sel = timer_prescaler_option_q[opt_pkg::src_edge_bit];
   wire prescaler_assign = timer_prescaler_option_q[opt_pkg::assign_bit];
   wire [2:0] prescale_rate_sel = timer_prescaler_option_q[2:0];

   // address decode
   wire hit_opt = (addr == opt_pkg::option_addr) | (addr == opt_pkg::option_alt_addr);
   wire wr_opt = wr_stb & hit_opt;
   wire wr_mask = wr_stb & (addr == opt_pkg::pullup_mask_addr);
   wire wr_intc = wr_stb & (addr == opt_pkg::int_ctrl_addr);
   wire wr_tmr = wr_stb & (addr == opt_pkg::timer_addr);
   wire wr_clr = wr_stb & (addr == opt_pkg::ev_clear_addr);
   wire wr_en = wr_stb & (addr == opt_pkg::ev_enable_addr);

   // timer source edges
   wire pin_rise = tpin_q[1] & ~tpin_q[2];
   wire pin_fall = ~tpin_q[1] & tpin_q[2];
   wire pin_edge = timer_src_edge_sel ? pin_fall : pin_rise;
   wire timer_src = timer_clk_src_sel ? pin_edge : 1'b1;

   wire pre_tick = prescaler_assign ? wdog_tick : timer_src;
   wire tap_timer;
   wire tap_wdog;

   prescaler_core u_pre
   (
      .clk(ref_clk),
      .rst_n(rst_n),
      .tick(pre_tick),
      .rate(prescale_rate_sel),
      .clear(wr_opt | wr_tmr),
      .tap_timer(tap_timer),
      .tap_wdog(tap_wdog)
   );

   // undivided timer when prescaler is on the watchdog
   wire timer_inc = prescaler_assign ? timer_src : tap_timer;
   wire wdog_evt = prescaler_assign ? tap_wdog : wdog_tick;
   wire timer_ovf = timer_inc & (eight_bit_timer_q == 8'hff) & ~wr_tmr;

   // external interrupt edge
   wire ext_rise = epin_q[1] & ~epin_q[2];
   wire ext_fall = ~epin_q[1] & epin_q[2];
   wire ext_evt = ext_int_edge_sel ? ext_rise : ext_fall;

   // peripheral requests gated by the peripheral gate bit, then the global bit
   wire periph_pend = (|periph_int_req) & interrupt_control_q[opt_pkg::periph_gate_bit];
   wire core_int_d = interrupt_control_q[opt_pkg::glob_int_bit] & periph_pend;

   wire [7:0] pullup_d = pullup_global_disable ? 8'h00 : port_b_pullup_mask_q;

   // sticky events, set wins over clear
   wire [1:0] ev_set = {ext_evt, timer_ovf};
   wire [1:0] ev_clr = wr_clr ? wdata[1:0] : 2'h0;
   wire [1:0] ev_status_d = (ev_status_q & ~ev_clr) | ev_set;
   wire irq_d = |(ev_status_d & ev_enable_q);

   // read mux
   wire [7:0] rd_mux =
      hit_opt ? timer_prescaler_option_q :
      (addr == opt_pkg::pullup_mask_addr) ? port_b_pullup_mask_q :
      (addr == opt_pkg::int_ctrl_addr) ? interrupt_control_q :
      (addr == opt_pkg::timer_addr) ? eight_bit_timer_q :
      (addr == opt_pkg::ev_status_addr) ? {6'h00, ev_status_q} :
      (addr == opt_pkg::ev_enable_addr) ? {6'h00, ev_enable_q} : 8'h00;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         timer_prescaler_option_q <= opt_pkg::option_reset;
      else if (wr_opt)
         timer_prescaler_option_q <= wdata;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         port_b_pullup_mask_q <= opt_pkg::pullup_mask_reset;
         interrupt_control_q <= opt_pkg::int_ctrl_reset;
         ev_enable_q <= opt_pkg::ev_reset;
      end
      else
      begin
         if (wr_mask)
            port_b_pullup_mask_q <= wdata;
         if (wr_intc)
            interrupt_control_q <= wdata;
         if (wr_en)
            ev_enable_q <= wdata[1:0];
      end
   end

   // timer count
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         eight_bit_timer_q <= 8'h00;
      else if (wr_tmr)
         eight_bit_timer_q <= wdata;
      else if (timer_inc)
         eight_bit_timer_q <= eight_bit_timer_q + 8'h01;
   end

   // registered outputs and status
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ev_status_q <= opt_pkg::ev_reset;
         rdata_q <= 8'h00;
         pullup_q <= 8'h00;
         core_int_q <= 1'b0;
         irq_q <= 1'b0;
         wdog_q <= 1'b0;
      end
      else
      begin
         ev_status_q <= ev_status_d;
         rdata_q <= rd_stb ? rd_mux : 8'h00;
         pullup_q <= pullup_d;
         core_int_q <= core_int_d;
         irq_q <= irq_d;
         wdog_q <= wdog_evt;
      end
   end

   assign rdata = rdata_q;
   assign port_b_pullup_en = pullup_q;
   assign core_int = core_int_q;
   assign irq = irq_q;
   assign wdog_timeout = wdog_q;

   gate_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !interrupt_control_q[opt_pkg::periph_gate_bit] |=> !core_int)
      else $error("peripheral interrupt passed closed gate");

   pullup_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pullup_global_disable |=> port_b_pullup_en == 8'h00)
      else $error("pull-ups on while globally disabled");

   timer_direct_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (prescaler_assign && !timer_clk_src_sel && !wr_tmr && !wr_opt)
      |=> eight_bit_timer_q == $past(eight_bit_timer_q) + 8'h01)
      else $error("timer not undivided under watchdog assignment");

   sequence opt_write_s;
      wr_opt ##1 rd_stb && hit_opt && !wr_stb;
   endsequence
   opt_readback_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      opt_write_s |=> rdata == $past(wdata, 2))
      else $error("option readback mismatch");

   reset_val_a: assert property (@(posedge ref_clk)
      $rose(rst_n) |-> timer_prescaler_option_q == 8'hff)
      else $error("option reset value wrong");

   wdog_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!prescaler_assign && wdog_tick) |=> wdog_timeout)
      else $error("watchdog divided while prescaler on timer");

   rate_div_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!prescaler_assign && !timer_clk_src_sel && prescale_rate_sel == 3'h0
       && !wr_opt && !wr_tmr) ##1 (!wr_opt && !wr_tmr)
      |=> eight_bit_timer_q == $past(eight_bit_timer_q, 2) + 8'h01)
      else $error("timer rate 1:2 not kept");

   // sticky event
   ev_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      timer_ovf |=> ev_status_q[opt_pkg::ev_timer_ovf])
      else $error("overflow event lost");
endmodule : timer_prescaler_option_reg

/* File: tb/timer_prescaler_option_reg_test.sv */
// self-checking bench for the option register block
`timescale 1ns/1ps
module timer_prescaler_option_reg_test;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [7:0] rdata;
   logic timer_pin = 1'b0;
   logic ext_int_pin = 1'b0;
   logic wdog_tick = 1'b0;
   logic [7:0] periph_int_req = 8'h00;
   logic wdog_timeout;
   logic [7:0] port_b_pullup_en;
   logic core_int;
   logic irq;
   int error_cnt = 0;
   int num_checks = 0;
   int wto_cnt = 0;
   int s;
   logic [7:0] v0, v1, m;

   timer_prescaler_option_reg uut (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .timer_pin(timer_pin),
      .ext_int_pin(ext_int_pin), .wdog_tick(wdog_tick), .periph_int_req(periph_int_req),
      .wdog_timeout(wdog_timeout), .port_b_pullup_en(port_b_pullup_en), .core_int(core_int),
      .irq(irq));

   // 20 MHz clock
   initial
   begin
      forever #25 ref_clk = ~ref_clk;
   end

   // count watchdog pulses
   always @(posedge ref_clk)
      if (wdog_timeout === 1'b1)
         wto_cnt <= wto_cnt + 1;

   // expectations
   function automatic logic [7:0] pull_exp(input logic [7:0] opt, input logic [7:0] msk);
      return opt[opt_pkg::pullup_dis_bit] ? 8'h00 : msk;
   endfunction : pull_exp
   function automatic logic core_exp(input logic [7:0] ic, input logic [7:0] req);
      return ic[opt_pkg::glob_int_bit] & ic[opt_pkg::periph_gate_bit] & (|req);
   endfunction : core_exp
   function automatic int tper(input logic [7:0] opt);
      return opt[opt_pkg::assign_bit] ? 1 : (2 << opt[2:0]);
   endfunction : tper
   function automatic logic [7:0] wexp(input logic [7:0] opt);
      return opt[opt_pkg::assign_bit] ? (8'h80 >> opt[2:0]) : 8'h80;
   endfunction : wexp

   // bus cycles and compare
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 d = rdata;
   endtask : rd
   // write then read with no idle cycle between the strobes
   task automatic wrrd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 q = rdata;
   endtask : wrrd
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask : rchk
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : settle
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   // hang guard
   initial
   begin
      #4000000;
      error_cnt++;
      summarize();
   end

   // main sequence
   initial
   begin
      s = $urandom(32'h6f9866cf);
      repeat (16) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rchk(opt_pkg::option_addr, opt_pkg::option_reset);
      rchk(opt_pkg::pullup_mask_addr, opt_pkg::pullup_mask_reset);
      rchk(opt_pkg::int_ctrl_addr, opt_pkg::int_ctrl_reset);
      rchk(8'h20, 8'h00);
      // random option and pull-up masks, both mirrors
      for (int i = 0; i < 8; i++)
      begin
         v0 = $urandom;
         v0[7] = i[1];
         m = $urandom;
         wr(i[0] ? opt_pkg::option_alt_addr : opt_pkg::option_addr, v0);
         wr(opt_pkg::pullup_mask_addr, m);
         rchk(opt_pkg::option_addr, v0);
         wrrd(opt_pkg::option_addr, v0, v1);
         chk(v1, v0);
         settle(2);
         chk(port_b_pullup_en, pull_exp(v0, m));
      end
      // peripheral gate combinations
      for (int i = 0; i < 8; i++)
      begin
         v0 = {i[2:1], 6'h00};
         @(posedge ref_clk);
         periph_int_req <= i[0] ? (8'h01 << ($urandom % 8)) : 8'h00;
         wr(opt_pkg::int_ctrl_addr, v0);
         rchk(opt_pkg::int_ctrl_addr, v0);
         settle(3);
         chk({7'h00, core_int}, {7'h00, core_exp(v0, periph_int_req)});
      end
      // timer rate per code, then watchdog assignment
      for (int k = 0; k < 9; k++)
      begin
         v0 = (k == 8) ? 8'h0f : {5'h00, k[2:0]};
         wr(opt_pkg::option_addr, v0);
         s = v0[3] ? 40 : tper(v0) * 3;
         rd(opt_pkg::timer_addr, v1);
         repeat (s - 2) @(posedge ref_clk);
         rd(opt_pkg::timer_addr, m);
         chk(m - v1, 8'(s / tper(v0)));
      end
      // watchdog postscale per code, then timer assignment
      for (int k = 0; k < 9; k++)
      begin
         v0 = (k == 8) ? 8'h07 : {5'h01, k[2:0]};
         wr(opt_pkg::option_addr, v0);
         s = wto_cnt;
         repeat (128)
         begin
            @(posedge ref_clk);
            wdog_tick <= 1'b1;
            @(posedge ref_clk);
            wdog_tick <= 1'b0;
         end
         settle(3);
         chk(8'(wto_cnt - s), wexp(v0));
      end
      // external timer pin, both edge selections
      for (int e = 0; e < 2; e++)
      begin
         wr(opt_pkg::option_addr, {3'h1, e[0], 4'h8});
         settle(6);
         v1 = $urandom;
         wr(opt_pkg::timer_addr, v1);
         rchk(opt_pkg::timer_addr, v1);
         rd(opt_pkg::timer_addr, v1);
         @(posedge ref_clk);
         timer_pin <= 1'b1;
         settle(6);
         rd(opt_pkg::timer_addr, m);
         @(posedge ref_clk);
         timer_pin <= 1'b0;
         settle(6);
         rd(opt_pkg::timer_addr, v0);
         chk(m - v1, {7'h00, ~e[0]});
         chk(v0 - m, {7'h00, e[0]});
      end
      // external interrupt edge, status, enable and clear
      for (int e = 0; e < 2; e++)
      begin
         wr(opt_pkg::option_addr, {1'b0, e[0], 6'h08});
         ext_int_pin <= e[0];
         settle(6);
         wr(opt_pkg::ev_clear_addr, 8'h02);
         wr(opt_pkg::ev_enable_addr, 8'h02);
         // unselected edge first, must not set the event
         ext_int_pin <= ~e[0];
         settle(6);
         chk({7'h00, irq}, 8'h00);
         @(posedge ref_clk);
         ext_int_pin <= e[0];
         settle(6);
         chk({7'h00, irq}, 8'h01);
         rd(opt_pkg::ev_status_addr, v1);
         chk(v1 & 8'h02, 8'h02);
         wr(opt_pkg::ev_enable_addr, 8'h00);
         settle(2);
         chk({7'h00, irq}, 8'h00);
      end
      summarize();
   end
endmodule : timer_prescaler_option_reg_test
